// File: design/alc_top.sv
`timescale 1ns/10ps
module alc_top
  import alc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [SAMPLE_W-1:0] ADC_SAMPLE,
  input wire logic ADC_VALID,
  input wire logic SENSOR_LAW_SELECT,
  input wire logic [1:0] GAIN_MODE,
  input wire logic AUTO_LUM_ON,
  input wire logic LED_DRIVE_ON,
  input wire logic LED_SOURCE_SELECT,
  input wire logic [CODE_W-1:0] MANUAL_CURRENT_CODE,
  input wire logic [3:0] RISE_RAMP_TIME,
  input wire logic [3:0] FALL_RAMP_TIME,
  input wire logic MODE_CHANGE_CURRENT_CLEAR,
  input wire logic EXT_PULSE_PERMIT,
  input wire logic EXT_PULSE_INPUT,
  input wire logic HW_RESET_N,
  input wire logic CODE_WR_EN,
  input wire logic [LEVEL_W-1:0] CODE_WR_LEVEL,
  input wire logic [CODE_W-1:0] CODE_WR_DATA,
  input wire logic [LEVEL_W-1:0] CODE_RD_LEVEL,
  output logic [CODE_W-1:0] CODE_RD_DATA,
  output logic [LEVEL_W-1:0] AMBIENT_LEVEL,
  output logic LEVEL_UPDATE,
  output logic GAIN_HIGH,
  output logic [STEP_W-1:0] LED_CURRENT_STEP,
  output logic LED_ON,
  output logic RAMP_BUSY,
  output logic I2C_INPUT_ENABLE
);

  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  alc_link_if lnk ();

  alc_ramp_t ramp_r;
  alc_ramp_t ramp_nxt;
  logic [STEP_W-1:0] cur_r;
  logic [STEP_W-1:0] cur_nxt;
  logic [11:0] cyc_r;
  logic [11:0] cyc_nxt;
  logic [3:0] unit_r;
  logic [3:0] unit_nxt;
  logic mode_r;
  logic [LEVEL_W-1:0] amb_r;
  logic upd_r;
  logic [STEP_W-1:0] out_step_r;
  logic led_on_r;
  logic busy_r;
  logic i2c_en_r;

  // ----------------------------------------------------------------
  // Sensor path and code store
  // ----------------------------------------------------------------
  alc_level_det u_det (
    .clk (REF_CLK),
    .rst (RESET),
    .sample (ADC_SAMPLE),
    .sample_valid (ADC_VALID),
    .law_sel (SENSOR_LAW_SELECT),
    .gain_mode (GAIN_MODE),
    .lnk (lnk.det)
  );

  alc_code_mem u_mem (
    .clk (REF_CLK),
    .rst (RESET),
    .lnk (lnk.mem)
  );

  // ----------------------------------------------------------------
  // Level and source selection
  // ----------------------------------------------------------------
  wire [LEVEL_W-1:0] eff_level = AUTO_LUM_ON ? lnk.level : LEVEL_ZERO;
  wire alc_mode = AUTO_LUM_ON && LED_SOURCE_SELECT;
  wire [CODE_W-1:0] target_code = LED_SOURCE_SELECT ?
    lnk.look_code : MANUAL_CURRENT_CODE;

  assign lnk.look_level = eff_level;
  assign lnk.wr_en = CODE_WR_EN;
  assign lnk.wr_level = CODE_WR_LEVEL;
  assign lnk.wr_code = CODE_WR_DATA;
  assign lnk.host_level = CODE_RD_LEVEL;

  // Doubling plus two: (code+1)*0.2 mA on a 0.1 mA scale, always even
  wire [STEP_W-1:0] code_step = {1'b0, target_code, 1'b0} + STEP_INC;
  wire [STEP_W-1:0] target_step = LED_DRIVE_ON ? code_step : STEP_ZERO;

  // ----------------------------------------------------------------
  // Mode change
  // ----------------------------------------------------------------
  wire mode_flip = LED_DRIVE_ON && alc_mode != mode_r;
  wire mode_clear = mode_flip && MODE_CHANGE_CURRENT_CLEAR;

  // ----------------------------------------------------------------
  // Ramp timing
  // ----------------------------------------------------------------
  wire [3:0] dwell = ramp_nxt == RAMP_UP ? RISE_RAMP_TIME : FALL_RAMP_TIME;
  wire unit_wrap = cyc_r == RAMP_CYC_LAST;
  wire step_due = ramp_nxt == ramp_r && ramp_r != RAMP_HOLD &&
    unit_wrap && unit_r >= dwell;

  always_comb
  begin
    if (cur_r < target_step)
      ramp_nxt = RAMP_UP;
    else if (cur_r > target_step)
      ramp_nxt = RAMP_DOWN;
    else
      ramp_nxt = RAMP_HOLD;
  end

  // A direction change starts a fresh dwell, so no step comes early
  always_comb
  begin
    if (ramp_nxt != ramp_r || ramp_nxt == RAMP_HOLD || step_due)
    begin
      cyc_nxt = 12'h000;
      unit_nxt = 4'h0;
    end
    else if (unit_wrap)
    begin
      cyc_nxt = 12'h000;
      unit_nxt = unit_r + 4'h1;
    end
    else
    begin
      cyc_nxt = cyc_r + 12'h001;
      unit_nxt = unit_r;
    end
  end

  // ----------------------------------------------------------------
  // Current value
  // ----------------------------------------------------------------
  always_comb
  begin
    cur_nxt = cur_r;
    if (!LED_DRIVE_ON)
      cur_nxt = STEP_ZERO;
    else if (mode_clear)
      cur_nxt = STEP_ZERO;
    else if (step_due)
    begin
      unique case (ramp_r)
        RAMP_UP: cur_nxt = cur_r + STEP_INC;
        RAMP_DOWN: cur_nxt = cur_r - STEP_INC;
        RAMP_HOLD: cur_nxt = cur_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // External pulse gating
  // ----------------------------------------------------------------
  // The ramp keeps running underneath, so gating never distorts the slope
  wire pulse_block = EXT_PULSE_PERMIT && !EXT_PULSE_INPUT;
  wire [STEP_W-1:0] gated_step = pulse_block ? STEP_ZERO : cur_nxt;
  wire led_on_nxt = LED_DRIVE_ON && !pulse_block && cur_nxt != STEP_ZERO;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ramp_r <= RAMP_HOLD;
      cur_r <= STEP_ZERO;
      cyc_r <= 12'h000;
      unit_r <= 4'h0;
      mode_r <= 1'b0;
    end
    else
    begin
      ramp_r <= ramp_nxt;
      cur_r <= cur_nxt;
      cyc_r <= cyc_nxt;
      unit_r <= unit_nxt;
      mode_r <= alc_mode;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      amb_r <= LEVEL_ZERO;
      upd_r <= 1'b0;
      out_step_r <= STEP_ZERO;
      led_on_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      amb_r <= eff_level;
      upd_r <= lnk.level_new;
      out_step_r <= gated_step;
      led_on_r <= led_on_nxt;
      busy_r <= ramp_nxt != RAMP_HOLD;
    end
  end

  // Buffers stay off until the first edge after the pin rises
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
      i2c_en_r <= 1'b0;
    else
      i2c_en_r <= HW_RESET_N;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign AMBIENT_LEVEL = amb_r;
  assign LEVEL_UPDATE = upd_r;
  assign GAIN_HIGH = lnk.gain_high;
  assign CODE_RD_DATA = lnk.host_code;
  assign LED_CURRENT_STEP = out_step_r;
  assign LED_ON = led_on_r;
  assign RAMP_BUSY = busy_r;
  assign I2C_INPUT_ENABLE = i2c_en_r;

endmodule // alc_top

// File: design/alc_pkg.sv
package alc_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 8;
  localparam int LEVEL_W = 4;
  localparam int CODE_W = 7;
  localparam int STEP_W = 9;
  localparam int LEVELS = 16;
  localparam logic [3:0] AVG_LAST = 4'hf;
  localparam int AVG_SHIFT = 4;

  // ----------------------------------------------------------------
  // Gain modes and levels
  // ----------------------------------------------------------------
  localparam logic [1:0] GAIN_AUTO = 2'h0;
  localparam logic [1:0] GAIN_MAN_HIGH = 2'h1;
  localparam logic [1:0] GAIN_MAN_LOW = 2'h2;
  localparam logic [1:0] GAIN_FIXED = 2'h3;
  localparam logic [3:0] LEVEL_ZERO = 4'h0;
  localparam logic [3:0] AUTO_TO_LOW_LEVEL = 4'hb;
  localparam logic [3:0] AUTO_TO_HIGH_LEVEL = 4'h5;
  localparam logic GAIN_HIGH_RESET = 1'b1;

  // ----------------------------------------------------------------
  // Lower level boundaries in 1/256 of full scale, Fh first
  // ----------------------------------------------------------------
  typedef logic [LEVELS-1:0][8:0] alc_thr_t;
  localparam alc_thr_t THR_LIN_HIGH = '{9'h100, 9'h100, 9'h100, 9'h100, 9'h0c8, 9'h072,
    9'h042, 9'h026, 9'h016, 9'h00d, 9'h008, 9'h005, 9'h003, 9'h002, 9'h001, 9'h000};
  localparam alc_thr_t THR_LIN_LOW = '{9'h0c8, 9'h073, 9'h041, 9'h025, 9'h015, 9'h00c,
    9'h007, 9'h004, 9'h002, 9'h001, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000};
  localparam alc_thr_t THR_LIN_FIXED = '{9'h0c8, 9'h091, 9'h069, 9'h04b, 9'h036, 9'h027,
    9'h01c, 9'h014, 9'h00e, 9'h00a, 9'h007, 9'h005, 9'h003, 9'h002, 9'h001, 9'h000};
  localparam alc_thr_t THR_LOG = '{9'h0b6, 9'h0a9, 9'h09c, 9'h090, 9'h084, 9'h078,
    9'h06c, 9'h060, 9'h054, 9'h048, 9'h03c, 9'h030, 9'h025, 9'h01b, 9'h012, 9'h000};

  // ----------------------------------------------------------------
  // Current codes after reset, Fh first
  // ----------------------------------------------------------------
  typedef logic [LEVELS-1:0][CODE_W-1:0] alc_codes_t;
  localparam alc_codes_t CODE_RESET = '{7'h63, 7'h63, 7'h63, 7'h63, 7'h63, 7'h5f, 7'h56,
    7'h48, 7'h3b, 7'h2f, 7'h25, 7'h1e, 7'h18, 7'h15, 7'h13, 7'h11};

  // ----------------------------------------------------------------
  // Ramp timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int RAMP_UNIT_US = 32;
  localparam int RAMP_UNIT_CYC = RAMP_UNIT_US * CLK_MHZ;
  localparam logic [11:0] RAMP_CYC_LAST = 12'(RAMP_UNIT_CYC - 1);
  localparam logic [STEP_W-1:0] STEP_INC = 9'h002;
  localparam logic [STEP_W-1:0] STEP_ZERO = 9'h000;

  typedef enum logic [1:0] {RAMP_HOLD, RAMP_UP, RAMP_DOWN} alc_ramp_t;

endpackage

// File: design/alc_link_if.sv
`timescale 1ns/10ps
interface alc_link_if;
  import alc_pkg::*;
  logic [LEVEL_W-1:0] level;
  logic gain_high;
  logic level_new;
  logic [LEVEL_W-1:0] look_level;
  logic [CODE_W-1:0] look_code;
  logic wr_en;
  logic [LEVEL_W-1:0] wr_level;
  logic [CODE_W-1:0] wr_code;
  logic [LEVEL_W-1:0] host_level;
  logic [CODE_W-1:0] host_code;

  modport det (output level, gain_high, level_new);
  modport mem (input look_level, wr_en, wr_level, wr_code, host_level,
    output look_code, host_code);
  modport ctl (input level, gain_high, level_new, look_code, host_code,
    output look_level, wr_en, wr_level, wr_code, host_level);
endinterface

// File: design/alc_code_mem.sv
`timescale 1ns/10ps
module alc_code_mem
  import alc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  alc_link_if.mem lnk
);

  logic [CODE_W-1:0] code_r [LEVELS];
  logic [CODE_W-1:0] look_r;
  logic [CODE_W-1:0] host_r;

  // ----------------------------------------------------------------
  // One writable code per level
  // ----------------------------------------------------------------
  for (genvar i = 0; i < LEVELS; i++)
  begin : g_entry
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        code_r[i] <= CODE_RESET[i];
      else if (lnk.wr_en && lnk.wr_level == 4'(i))
        code_r[i] <= lnk.wr_code;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      look_r <= CODE_RESET[0];
      host_r <= CODE_RESET[0];
    end
    else
    begin
      look_r <= code_r[lnk.look_level];
      host_r <= code_r[lnk.host_level];
    end
  end

  assign lnk.look_code = look_r;
  assign lnk.host_code = host_r;

endmodule // alc_code_mem

// File: design/alc_level_det.sv
`timescale 1ns/10ps
module alc_level_det
  import alc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [SAMPLE_W-1:0] sample,
  input wire logic sample_valid,
  input wire logic law_sel,
  input wire logic [1:0] gain_mode,
  alc_link_if.det lnk
);

  logic [11:0] acc_r;
  logic [3:0] cnt_r;
  logic [LEVEL_W-1:0] level_r;
  logic new_r;
  logic gain_high_r;
  logic [4:0] hit_cnt;

  // ----------------------------------------------------------------
  // Averaging and ranking
  // ----------------------------------------------------------------
  wire [11:0] sum_w = acc_r + {4'h0, sample};
  wire avg_done = sample_valid && cnt_r == AVG_LAST;
  wire [8:0] avg_w = {1'b0, sum_w[11:AVG_SHIFT]};
  wire auto_gain = gain_mode == GAIN_AUTO && !law_sel;
  wire alc_thr_t thr_w = law_sel ? THR_LOG :
    gain_mode == GAIN_FIXED ? THR_LIN_FIXED :
    gain_high_r ? THR_LIN_HIGH : THR_LIN_LOW;
  wire [LEVELS-1:0] hit_w;

  for (genvar i = 0; i < LEVELS; i++)
  begin : g_cmp
    assign hit_w[i] = avg_w >= thr_w[i];
  end

  always_comb
  begin
    hit_cnt = 5'h00;
    for (int i = 0; i < LEVELS; i++)
      hit_cnt = hit_cnt + {4'h0, hit_w[i]};
  end

  // Entry 0 is always hit, so the count never underflows
  wire [LEVEL_W-1:0] level_w = 4'(hit_cnt - 5'h01);
  wire to_low = gain_high_r && level_w == AUTO_TO_LOW_LEVEL;
  wire to_high = !gain_high_r && level_w == AUTO_TO_HIGH_LEVEL;
  wire gain_nxt = !auto_gain ? gain_mode != GAIN_MAN_LOW :
    (avg_done && (to_low || to_high)) ? !gain_high_r : gain_high_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acc_r <= 12'h000;
      cnt_r <= 4'h0;
      level_r <= LEVEL_ZERO;
      new_r <= 1'b0;
      gain_high_r <= GAIN_HIGH_RESET;
    end
    else
    begin
      new_r <= avg_done;
      gain_high_r <= gain_nxt;
      // Restart the average after a gain switch: mixed-gain samples mean nothing
      if (avg_done || gain_nxt != gain_high_r)
      begin
        acc_r <= 12'h000;
        cnt_r <= 4'h0;
      end
      else if (sample_valid)
      begin
        acc_r <= sum_w;
        cnt_r <= cnt_r + 4'h1;
      end
      if (avg_done)
        level_r <= level_w;
    end
  end

  assign lnk.level = level_r;
  assign lnk.gain_high = gain_high_r;
  assign lnk.level_new = new_r;

endmodule // alc_level_det

// File: testbench/alc_far_model.sv
`timescale 1ns/10ps
module alc_far_model
  #(parameter int HIGH_MIN = 5000)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [7:0] lux,
  input wire logic pwm_req,
  output logic [7:0] adc_sample,
  output logic adc_valid,
  output logic pwm_pin
);
  logic [1:0] ph;
  logic odd;
  int hcnt;
  initial
  begin
    adc_sample = 8'h00;
    adc_valid = 1'b0;
    pwm_pin = 1'b1;
    ph = 2'h0;
    odd = 1'b0;
    hcnt = 0;
  end
  // ----------------------------------------------------------------
  // Sensor: v and v+1 alternate, so only a true average lands on v
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst)
    if (rst)
      adc_valid <= 1'b0;
    else
    begin
      ph <= ph + 2'h1;
      adc_valid <= run && ph == 2'h3;
      odd <= odd ^ (run && ph == 2'h3);
      adc_sample <= (run && ph == 2'h3) ? lux + 8'(odd) : ~adc_sample;
    end
  // ----------------------------------------------------------------
  // Pulse pin: a high phase is never cut short
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst)
    if (rst)
      hcnt <= 0;
    else if (!pwm_pin || hcnt >= HIGH_MIN)
    begin
      pwm_pin <= pwm_req;
      hcnt <= pwm_req ? hcnt + 1 : 0;
    end
    else
      hcnt <= hcnt + 1;
endmodule // alc_far_model

// File: testbench/alc_top_chk.sv
`timescale 1ns/10ps
module alc_top_chk
  import alc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [1:0] GAIN_MODE,
  input wire logic AUTO_LUM_ON,
  input wire logic LED_DRIVE_ON,
  input wire logic LED_SOURCE_SELECT,
  input wire logic MODE_CHANGE_CURRENT_CLEAR,
  input wire logic EXT_PULSE_PERMIT,
  input wire logic EXT_PULSE_INPUT,
  input wire logic HW_RESET_N,
  input wire logic [LEVEL_W-1:0] AMBIENT_LEVEL,
  input wire logic LEVEL_UPDATE,
  input wire logic GAIN_HIGH,
  input wire logic [STEP_W-1:0] LED_CURRENT_STEP,
  input wire logic I2C_INPUT_ENABLE
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  logic auto_mode;
  logic [STEP_W-1:0] cur;
  assign auto_mode = AUTO_LUM_ON & LED_SOURCE_SELECT;
  assign cur = LED_CURRENT_STEP;
  a_input_enable_follow:
    assert property (!$past(RESET) |-> I2C_INPUT_ENABLE == $past(HW_RESET_N))
    else $error("input enable wrong");
  a_gate_forces_off:
    assert property (EXT_PULSE_PERMIT && !EXT_PULSE_INPUT |=> cur == 9'h000)
    else $error("current not gated");
  a_drive_off_zero:
    assert property (!LED_DRIVE_ON ##1 !LED_DRIVE_ON |=> cur == 9'h000)
    else $error("current with drive off");
  a_step_scale:
    assert property (cur[0] == 1'b0 && cur <= 9'h100)
    else $error("current off scale");
  a_step_by_two:
    assert property ($changed(cur) && $past(cur) != 9'h000 && cur != 9'h000
      |-> cur - $past(cur) == 9'h002 || $past(cur) - cur == 9'h002)
    else $error("step not two");
  a_update_spacing:
    assert property (LEVEL_UPDATE |=> !LEVEL_UPDATE [*8])
    else $error("updates too close");
  a_auto_off_level:
    assert property (!AUTO_LUM_ON |=> AMBIENT_LEVEL == LEVEL_ZERO)
    else $error("level with auto off");
  a_manual_low_gain:
    assert property (GAIN_MODE == GAIN_MAN_LOW |=> GAIN_HIGH == 1'b0)
    else $error("gain not low");
  a_clear_restart:
    assert property ($changed(auto_mode) && LED_DRIVE_ON && MODE_CHANGE_CURRENT_CLEAR
      |-> ##[1:3] cur == 9'h000)
    else $error("current not cleared");
endmodule // alc_top_chk
bind alc_top alc_top_chk u_chk (.REF_CLK, .RESET, .GAIN_MODE, .AUTO_LUM_ON, .LED_DRIVE_ON,
  .LED_SOURCE_SELECT, .MODE_CHANGE_CURRENT_CLEAR, .EXT_PULSE_PERMIT, .EXT_PULSE_INPUT,
  .HW_RESET_N, .AMBIENT_LEVEL, .LEVEL_UPDATE, .GAIN_HIGH, .LED_CURRENT_STEP,
  .I2C_INPUT_ENABLE);

// File: testbench/alc_top_tb.sv
`timescale 1ns/10ps
module alc_top_tb;
  import alc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, law = 1'b0, auto = 1'b1, drv = 1'b0, src = 1'b0;
  logic clr = 1'b1, perm = 1'b1, hwn = 1'b0, wr = 1'b0, run = 1'b0, preq = 1'b1;
  logic [1:0] gm = GAIN_FIXED;
  logic [3:0] rise = 4'h0, fall = 4'h0, wl = 4'h0, rl = 4'h0, amb;
  logic [6:0] man = 7'h00, wd = 7'h00, rd;
  logic [7:0] lux = 8'h00, smp;
  logic [8:0] cur;
  logic vld, upd, gh, on, busy, ien, pin;
  logic [31:0] seed = 32'h7fc81e0e;
  int cmp_count = 0, n_mismatch = 0;
  logic [6:0] codes [16];
  logic [6:0] rcode [16] = '{7'h11, 7'h13, 7'h15, 7'h18, 7'h1e, 7'h25, 7'h2f, 7'h3b, 7'h48,
    7'h56, 7'h5f, 7'h63, 7'h63, 7'h63, 7'h63, 7'h63};
  logic [1:0] rmode [4] = '{GAIN_FIXED, GAIN_FIXED, GAIN_MAN_HIGH, GAIN_MAN_LOW};
  // Unused entries sit above any sample
  int thr [4][16] = '{'{0, 1, 2, 3, 5, 7, 10, 14, 20, 28, 39, 54, 75, 105, 145, 200},
    '{0, 18, 27, 37, 48, 60, 72, 84, 96, 108, 120, 132, 144, 156, 169, 182},
    '{0, 1, 2, 3, 5, 8, 13, 22, 38, 66, 114, 200, 999, 999, 999, 999},
    '{0, 1, 2, 4, 7, 12, 21, 37, 65, 115, 200, 999, 999, 999, 999, 999}};
  always #5 clk = ~clk;
  alc_top u_dut (.REF_CLK(clk), .RESET(rst), .ADC_SAMPLE(smp), .ADC_VALID(vld),
    .SENSOR_LAW_SELECT(law), .GAIN_MODE(gm), .AUTO_LUM_ON(auto), .LED_DRIVE_ON(drv),
    .LED_SOURCE_SELECT(src), .MANUAL_CURRENT_CODE(man), .RISE_RAMP_TIME(rise),
    .FALL_RAMP_TIME(fall), .MODE_CHANGE_CURRENT_CLEAR(clr), .EXT_PULSE_PERMIT(perm),
    .EXT_PULSE_INPUT(pin), .HW_RESET_N(hwn), .CODE_WR_EN(wr), .CODE_WR_LEVEL(wl),
    .CODE_WR_DATA(wd), .CODE_RD_LEVEL(rl), .CODE_RD_DATA(rd), .AMBIENT_LEVEL(amb),
    .LEVEL_UPDATE(upd), .GAIN_HIGH(gh), .LED_CURRENT_STEP(cur), .LED_ON(on),
    .RAMP_BUSY(busy), .I2C_INPUT_ENABLE(ien));
  alc_far_model #(.HIGH_MIN(5000)) u_far (.clk(clk), .rst(rst), .run(run), .lux(lux),
    .pwm_req(preq), .adc_sample(smp), .adc_valid(vld), .pwm_pin(pin));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [8:0] exp_level(int row, int v);
    int n = 0;
    for (int i = 0; i < 16; i++)
      if (v >= thr[row][i])
        n++;
    return 9'(n - 1 + (row == 3 ? 5 : 0));
  endfunction
  task automatic cmp_val(string what, logic [8:0] e, logic [8:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_cyc(string what, int e, int g);
    cmp_count++;
    if (g != e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %0d seen %0d", what, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  // First update after a change may still mix old samples
  task automatic wait_upd;
    int t = 0;
    repeat (2)
    begin
      tick(1);
      while (upd !== 1'b1 && t < 300)
      begin
        tick(1);
        t++;
      end
    end
    if (t >= 300)
      n_mismatch++;
  endtask
  task automatic wait_step(output int c);
    logic [8:0] s0;
    s0 = cur;
    c = 0;
    while (cur === s0 && c < 20000)
    begin
      tick(1);
      c++;
    end
  endtask
  task automatic read_codes(logic [6:0] e [16]);
    foreach (e[i])
    begin
      rl = 4'(i);
      tick(1);
      cmp_val("level code", 9'(e[i]), 9'(rd));
    end
  endtask
  task automatic level_case(int row, int v);
    lux = 8'(v);
    wait_upd();
    cmp_val("ambient level", exp_level(row, v), 9'(amb));
  endtask
  // ----------------------------------------------------------------
  // Sequence, near 50k cycles
  // ----------------------------------------------------------------
  initial
  begin
    #900000;
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    int c;
    tick(12);
    rst = 1'b0;
    cmp_val("input enable", 9'h000, 9'(ien));
    hwn = 1'b1;
    run = 1'b1;
    read_codes(rcode);
    cmp_val("input enable", 9'h001, 9'(ien));
    for (int r = 0; r < 4; r++)
    begin
      law = (r == 1);
      gm = rmode[r];
      for (int i = 1; i < 16; i++)
        if (thr[r][i] < 256)
        begin
          level_case(r, thr[r][i] - 1);
          level_case(r, thr[r][i]);
        end
      repeat (3)
      begin
        seed = lfsr(seed);
        level_case(r, int'(seed[7:0] % 8'hff));
      end
    end
    law = 1'b0;
    gm = GAIN_AUTO;
    lux = 8'hfa;
    repeat (2) wait_upd();
    cmp_val("gain", 9'h000, 9'(gh));
    cmp_val("ambient level", 9'h00f, 9'(amb));
    lux = 8'h00;
    repeat (2) wait_upd();
    cmp_val("gain", 9'h001, 9'(gh));
    auto = 1'b0;
    tick(3);
    cmp_val("level auto off", 9'h000, 9'(amb));
    auto = 1'b1;
    wr = 1'b1;
    foreach (codes[i])
    begin
      seed = lfsr(seed);
      codes[i] = (i == 0) ? 7'h01 : seed[6:0];
      wl = 4'(i);
      wd = codes[i];
      tick(1);
    end
    wr = 1'b0;
    tick(1);
    read_codes(codes);
    man = 7'h02;
    rise = 4'h1;
    drv = 1'b1; // Permit and pin high already
    wait_step(c);
    cmp_val("first step", 9'h002, cur);
    wait_step(c);
    cmp_cyc("rise dwell", 2 * RAMP_UNIT_CYC, c);
    preq = 1'b0;
    tick(3);
    cmp_val("gated", 9'h000, cur);
    cmp_val("busy", 9'h001, 9'(busy));
    preq = 1'b1;
    tick(3);
    cmp_val("ungated", 9'h004, cur);
    wait_step(c);
    tick(2);
    cmp_val("rise end", 9'h006, cur);
    cmp_val("busy", 9'h000, 9'(busy));
    cmp_val("led on", 9'h001, 9'(on));
    man = 7'h00;
    wait_step(c);
    wait_step(c);
    cmp_cyc("fall dwell", RAMP_UNIT_CYC, c);
    perm = 1'b0;
    preq = 1'b0;
    tick(5);
    cmp_val("pin ignored", 9'h002, cur);
    preq = 1'b1;
    tick(2);
    perm = 1'b1;
    rise = 4'h0;
    src = 1'b1;
    tick(4);
    cmp_val("cleared", 9'h000, cur);
    wait_step(c);
    wait_step(c);
    cmp_val("level target", 9'h004, cur);
    clr = 1'b0;
    src = 1'b0;
    tick(4);
    cmp_val("kept", 9'h004, cur);
    wait_step(c);
    cmp_val("manual target", 9'h002, cur);
    drv = 1'b0;
    tick(3);
    cmp_val("drive off", 9'h000, cur);
    hwn = 1'b0;
    tick(2);
    cmp_val("input enable", 9'h000, 9'(ien));
    print_verdict();
  end
endmodule // alc_top_tb
